/* core/uart_pkg.sv */
// Constants shared by the pin-programmed asynchronous serial transceiver
package uart_pkg;
    // Bit timing: sixteen ticks of the 16x clock per bit cell
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam logic [3:0]  TICK_LAST     = 4'hf;
    localparam logic [3:0]  START_CENTER  = 4'h7;
    localparam logic [7:0]  HALF_BIT      = 8'h08;
    // Crystal prescaler ratios
    localparam logic [10:0] DIV_FAST      = 11'h00f;
    localparam logic [10:0] DIV_SLOW      = 11'h7ff;
    // Character length: base length plus the two select bits
    localparam logic [3:0]  LEN_BASE      = 4'h5;
    // Control word layout and reset value
    localparam int unsigned CW_LEN0       = 0;
    localparam int unsigned CW_LEN1       = 1;
    localparam int unsigned CW_PINH       = 2;
    localparam int unsigned CW_EVEN       = 3;
    localparam int unsigned CW_STOP       = 4;
    localparam logic [4:0]  CW_RESET      = 5'h00;
    // Idle transmit frame is all marks
    localparam logic [11:0] FRAME_IDLE    = 12'hfff;
    // Receive states
    typedef enum logic [1:0] {rx_idle, rx_start, rx_bits, rx_stop} rx_state_type;
endpackage

/* core/pin_uart.sv */
// Pin-programmed full-duplex asynchronous serial transceiver
`timescale 1ns/1ps
module pin_uart
    import uart_pkg::*;
#(
    parameter bit CRYSTAL_VARIANT = 1'b0 // Internal prescaler, always-driven status
)(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    // Bit clocks and prescaler (external pins)
    input  wire logic       rx_bit_clock_16x_in,
    input  wire logic       tx_bit_clock_16x_in,
    input  wire logic       prescale_select_in,
    // Serial lines
    input  wire logic       rx_serial_in,
    output logic            tx_serial_out_out,
    // Control word pins
    input  wire logic       ctrl_word_load_in,
    input  wire logic       char_len_sel_0_in,
    input  wire logic       char_len_sel_1_in,
    input  wire logic       parity_inhibit_in,
    input  wire logic       even_parity_select_in,
    input  wire logic       stop_len_select_in,
    // Transmit side
    input  wire logic [7:0] tx_holding_data_in,
    input  wire logic       tx_holding_load_n_in,
    input  wire logic       master_reset_in,
    output logic            tx_holding_empty_out,
    output logic            tx_holding_empty_oe_n_out,
    output logic            tx_shift_empty_out,
    // Receive side
    input  wire logic       rx_ready_clear_n_in,
    input  wire logic       rx_data_output_disable_in,
    input  wire logic       flag_output_disable_in,
    output logic [7:0]      rx_holding_data_out,
    output logic            rx_holding_data_oe_n_out,
    output logic            rx_char_ready_out,
    output logic            rx_char_ready_oe_n_out,
    output logic            rx_parity_fault_out,
    output logic            framing_fault_out,
    output logic            overrun_fault_out,
    output logic            flags_oe_n_out
);

    // All pins are asynchronous to clk_sys_in: two flops each
    logic [22:0]  pin_meta_q;   // First stage, read only by second
    logic [22:0]  pin_q;        // Second stage, safe to use
    logic [1:0]   clk_prev_q;   // Previous bit-clock levels
    logic         load_prev_q;  // Previous load strobe level
    wire  [22:0]  pin_raw = {rx_serial_in, rx_bit_clock_16x_in,
                             tx_bit_clock_16x_in, prescale_select_in,
                             ctrl_word_load_in, char_len_sel_0_in,
                             char_len_sel_1_in, parity_inhibit_in,
                             even_parity_select_in, stop_len_select_in,
                             tx_holding_load_n_in, master_reset_in,
                             rx_ready_clear_n_in, rx_data_output_disable_in,
                             flag_output_disable_in, tx_holding_data_in};

    // Named views of the synchronised pins
    wire       rxd      = pin_q[22];
    wire       rx_clk   = pin_q[21];
    wire       tx_clk   = pin_q[20];
    wire       presc    = pin_q[19];
    wire       ctrl_word_load      = pin_q[18];
    wire [4:0] cw_pins  = {pin_q[13], pin_q[14], pin_q[15], pin_q[16],
                           pin_q[17]};
    wire       load_n   = pin_q[12];
    wire       mr       = pin_q[11];
    wire       drr_n    = pin_q[10];
    wire       rx_data_output_disable      = pin_q[9];
    wire       flag_output_disable      = pin_q[8];
    wire [7:0] tx_data  = pin_q[7:0];

    // Synchroniser and edge history; bit clocks reset low so no false tick
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pin_meta_q  <= 23'h481c00;
            pin_q       <= 23'h481c00;
            clk_prev_q  <= 2'h0;
            load_prev_q <= 1'b1;
        end
        else
        begin
            pin_meta_q  <= pin_raw;
            pin_q       <= pin_meta_q;
            clk_prev_q  <= {rx_clk, tx_clk};
            load_prev_q <= load_n;
        end
    end

    // Crystal prescaler: one divider feeds both directions
    logic [10:0] div_q;         // Prescaler count
    wire  [10:0] div_top   = presc ? DIV_FAST : DIV_SLOW;
    wire         div_tick  = (div_q == div_top);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            div_q <= 11'h000;
        else if (div_tick || div_q > div_top)
            div_q <= 11'h000;
        else
            div_q <= div_q + 11'h001;
    end

    // 16x tick enables; external clocks counted on rising edges
    wire rx_tick = CRYSTAL_VARIANT ? div_tick : (rx_clk & ~clk_prev_q[1]);
    wire tx_tick = CRYSTAL_VARIANT ? div_tick : (tx_clk & ~clk_prev_q[0]);

    // Control register, transparent while its load pin is high
    logic [4:0] cw_q;           // Control word

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            cw_q <= CW_RESET;
        else if (ctrl_word_load)
            cw_q <= cw_pins;
    end

    // Character format decode
    wire [3:0] char_len  = LEN_BASE + {2'h0, cw_q[CW_LEN1], cw_q[CW_LEN0]};
    wire       par_en    = ~cw_q[CW_PINH];
    wire       even_par  = cw_q[CW_EVEN];
    wire       len_five  = (char_len == LEN_BASE);
    wire [7:0] len_mask  = ~(8'hff << char_len);
    wire [3:0] body_bits = char_len + {3'h0, par_en};
    wire [1:0] stop_full = cw_q[CW_STOP] ? (len_five ? 2'h1 : 2'h2) : 2'h1;
    wire       stop_half = cw_q[CW_STOP] & len_five;

    // Parity bit that makes the masked character even or odd
    function automatic logic parity_of(input logic [7:0] d, input logic ev);
        parity_of = ev ? ^d : ~^d;
    endfunction

    // Transmit frame assembly
    logic [7:0] tx_hold_q;      // Holding latch
    wire [7:0]  tx_masked = tx_hold_q & len_mask;
    wire        tx_par    = parity_of(tx_masked, even_par) | ~par_en;
    wire [8:0]  tx_body   = (9'h1ff << body_bits) | {1'b0, tx_masked}
                            | ({8'h00, tx_par} << char_len);
    wire [11:0] tx_frame  = {2'h3, tx_body, 1'b0};
    wire [7:0]  tx_ticks  = {body_bits + 4'h1 + {2'h0, stop_full}, 4'h0}
                            + (stop_half ? HALF_BIT : 8'h00);

    // Transmit state
    logic        tx_pend_q;     // Move to shifter requested
    logic        tx_busy_q;     // Shifter sending
    logic [11:0] tx_frame_q;    // Shifter; bit zero is the line
    logic [7:0]  tx_left_q;     // Ticks left in the frame
    logic [3:0]  tx_sub_q;      // Tick within the bit cell
    logic        tx_hempty_q;   // Holding latch empty
    logic        tx_sempty_q;   // Shifter empty
    logic        tx_mr_pend_q;  // Shifter empty due after reset
    wire         load_rise = load_n & ~load_prev_q;
    wire         tx_last   = tx_busy_q & (tx_left_q == 8'h01);
    wire         tx_start  = tx_tick & tx_pend_q & (~tx_busy_q | tx_last);

    // Transmitter: holding latch, queued move and bit shifting
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_hold_q    <= 8'h00;
            tx_pend_q    <= 1'b0;
            tx_busy_q    <= 1'b0;
            tx_frame_q   <= FRAME_IDLE;
            tx_left_q    <= 8'h00;
            tx_sub_q     <= 4'h0;
            tx_hempty_q  <= 1'b1;
            tx_sempty_q  <= 1'b0;
            tx_mr_pend_q <= 1'b1;
        end
        else if (mr)
        begin
            // Master reset: idle line, empty latch, shifter flag low
            tx_pend_q    <= 1'b0;
            tx_busy_q    <= 1'b0;
            tx_frame_q   <= FRAME_IDLE;
            tx_hempty_q  <= 1'b1;
            tx_sempty_q  <= 1'b0;
            tx_mr_pend_q <= 1'b1;
        end
        else
        begin
            // Latch follows the data pins while the strobe is low
            if (!load_n)
                tx_hold_q <= tx_data;
            if (tx_start)
            begin
                // Latch hands over; sending starts with the start bit
                tx_frame_q  <= tx_frame;
                tx_left_q   <= tx_ticks;
                tx_sub_q    <= 4'h0;
                tx_busy_q   <= 1'b1;
                tx_pend_q   <= 1'b0;
                tx_hempty_q <= 1'b1;
                tx_sempty_q <= 1'b0;
            end
            else if (tx_tick && tx_busy_q)
            begin
                tx_sub_q  <= tx_sub_q + 4'h1;
                tx_left_q <= tx_left_q - 8'h01;
                if (tx_sub_q == TICK_LAST)
                    tx_frame_q <= {1'b1, tx_frame_q[11:1]};
                if (tx_last)
                begin
                    // Last stop tick gone: nothing queued behind it
                    tx_busy_q   <= 1'b0;
                    tx_frame_q  <= FRAME_IDLE;
                    tx_sempty_q <= 1'b1;
                end
            end
            else if (tx_tick && tx_mr_pend_q)
            begin
                // First tick after reset reports an idle shifter
                tx_sempty_q  <= 1'b1;
                tx_mr_pend_q <= 1'b0;
            end
            // New strobe after a start keeps the request alive
            if (load_rise)
            begin
                tx_pend_q   <= 1'b1;
                tx_hempty_q <= 1'b0;
            end
        end
    end

    // Receive state
    rx_state_type rx_state_q;   // Receiver phase
    logic [3:0]   rx_sub_q;     // Tick within the bit cell
    logic [3:0]   rx_bit_q;     // Body bit index
    logic [8:0]   rx_sr_q;      // Assembled data and parity
    logic [7:0]   rx_hold_q;    // Holding register
    logic         rx_stop_q;    // Sampled first stop bit
    logic         rx_late_q;    // Second half of the transfer
    logic         rx_ready_q;   // Character ready
    logic         rx_pe_q;      // Parity fault
    logic         rx_fe_q;      // Framing fault
    logic         rx_ov_q;      // Overrun fault
    logic         drr_seen_q;   // Ready-clear seen since last transfer
    wire          rx_cell_end = rx_tick & (rx_sub_q == TICK_LAST);
    wire          rx_xfer     = rx_cell_end & (rx_state_q == rx_stop);
    wire [7:0]    rx_char     = rx_sr_q[7:0] & len_mask;
    wire          rx_par_bad  = par_en
                                & (rx_sr_q[char_len] != parity_of(rx_char, even_par));

    // Receiver sequencer; the line is assumed high when idle
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_state_q <= rx_idle;
            rx_sub_q   <= 4'h0;
            rx_bit_q   <= 4'h0;
            rx_sr_q    <= 9'h000;
        end
        else if (rx_tick)
        begin
            rx_sub_q <= rx_sub_q + 4'h1;
            unique case (rx_state_q)
                rx_idle:
                    if (!rxd)
                    begin
                        rx_state_q <= rx_start;
                        rx_sub_q   <= 4'h0;
                    end
                rx_start:
                    if (rx_sub_q == START_CENTER)
                    begin
                        // A glitch that is high mid-cell is no start bit
                        rx_state_q <= rxd ? rx_idle : rx_bits;
                        rx_sub_q   <= 4'h0;
                        rx_bit_q   <= 4'h0;
                    end
                rx_bits:
                    if (rx_sub_q == TICK_LAST)
                    begin
                        rx_sr_q[rx_bit_q] <= rxd;
                        rx_bit_q          <= rx_bit_q + 4'h1;
                        if (rx_bit_q == body_bits - 4'h1)
                            rx_state_q <= rx_stop;
                    end
                rx_stop:
                    if (rx_sub_q == TICK_LAST)
                        rx_state_q <= rx_idle;
            endcase
        end
    end

    // Holding register and receive flags
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_hold_q  <= 8'h00;
            rx_stop_q  <= 1'b1;
            rx_late_q  <= 1'b0;
            rx_ready_q <= 1'b0;
            rx_pe_q    <= 1'b0;
            rx_fe_q    <= 1'b0;
            rx_ov_q    <= 1'b0;
            drr_seen_q <= 1'b0;
        end
        else
        begin
            rx_late_q <= rx_xfer & ~mr;
            if (rx_xfer)
            begin
                // Holding register survives master reset
                rx_hold_q <= rx_char;
                rx_stop_q <= rxd;
            end
            if (mr)
            begin
                rx_ready_q <= 1'b0;
                rx_pe_q    <= 1'b0;
                rx_fe_q    <= 1'b0;
                rx_ov_q    <= 1'b0;
                drr_seen_q <= 1'b0;
            end
            else
            begin
                // Clear level wins over the late set
                if (!drr_n)
                    rx_ready_q <= 1'b0;
                else if (rx_late_q)
                    rx_ready_q <= 1'b1;
                if (rx_xfer)
                begin
                    rx_pe_q    <= rx_par_bad;
                    rx_ov_q    <= rx_ready_q | (rx_ov_q & ~drr_seen_q);
                    drr_seen_q <= ~drr_n;
                end
                else if (!drr_n)
                    drr_seen_q <= 1'b1;
                if (rx_late_q)
                    rx_fe_q <= ~rx_stop_q;
                // Inhibited parity drops the fault at once
                if (!par_en)
                    rx_pe_q <= 1'b0;
            end
        end
    end

    // Output enables, registered from the disable pins
    logic rrd_q;                // Data disable
    logic sfd_q;                // Flag disable
    logic stat_dis_q;           // Status disable, non-crystal only

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rrd_q      <= 1'b1;
            sfd_q      <= 1'b1;
            stat_dis_q <= 1'b0;
        end
        else
        begin
            rrd_q      <= rx_data_output_disable;
            sfd_q      <= flag_output_disable;
            stat_dis_q <= flag_output_disable & ~CRYSTAL_VARIANT;
        end
    end

    // Outputs come straight from flops
    assign tx_serial_out_out         = tx_frame_q[0];
    assign tx_holding_empty_out      = tx_hempty_q;
    assign tx_holding_empty_oe_n_out = stat_dis_q;
    assign tx_shift_empty_out        = tx_sempty_q;
    assign rx_holding_data_out       = rx_hold_q;
    assign rx_holding_data_oe_n_out  = rrd_q;
    assign rx_char_ready_out         = rx_ready_q;
    assign rx_char_ready_oe_n_out    = stat_dis_q;
    assign rx_parity_fault_out       = rx_pe_q;
    assign framing_fault_out         = rx_fe_q;
    assign overrun_fault_out         = rx_ov_q;
    assign flags_oe_n_out            = sfd_q;

endmodule

/* sim/pin_uart_chk.sv */
// Pin-level concurrent checks for the serial transceiver
`timescale 1ns/1ps
module pin_uart_chk (
    // Watched top-level pins
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic master_reset_in,
    input wire logic tx_holding_load_n_in,
    input wire logic rx_ready_clear_n_in,
    input wire logic rx_data_output_disable_in,
    input wire logic flag_output_disable_in,
    input wire logic tx_serial_out_out,
    input wire logic tx_holding_empty_out,
    input wire logic tx_holding_empty_oe_n_out,
    input wire logic tx_shift_empty_out,
    input wire logic rx_holding_data_oe_n_out,
    input wire logic rx_char_ready_out,
    input wire logic rx_char_ready_oe_n_out,
    input wire logic overrun_fault_out,
    input wire logic flags_oe_n_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    // Load edge fills the latch; a later tick moves it to the shifter
    sequence s_latch_full;
        ##[1:6] !tx_holding_empty_out;
    endsequence
    sequence s_moved;
        ##[1:30] tx_holding_empty_out && !tx_shift_empty_out;
    endsequence
    property p_load; $rose(tx_holding_load_n_in) |-> s_latch_full; endproperty
    a_load: assert property (p_load) else $error("empty flag missed load edge");
    property p_move; $fell(tx_holding_empty_out) && tx_shift_empty_out |-> s_moved; endproperty
    a_move: assert property (p_move) else $error("latch not moved to shifter");
    property p_start; $fell(tx_serial_out_out) |-> ##[0:2] !tx_shift_empty_out; endproperty
    a_start: assert property (p_start) else $error("start bit while shifter empty");
    // Shifter only reports empty after the line has sat at mark
    property p_done; $rose(tx_shift_empty_out) |-> tx_serial_out_out && $past(tx_serial_out_out, 4);
    endproperty
    a_done: assert property (p_done) else $error("shifter empty before stop");
    property p_mr; master_reset_in [*5] |-> tx_serial_out_out && tx_holding_empty_out
        && !tx_shift_empty_out && !rx_char_ready_out && !overrun_fault_out; endproperty
    a_mr: assert property (p_mr) else $error("master reset outputs wrong");
    property p_clr; !rx_ready_clear_n_in [*4] |-> !rx_char_ready_out; endproperty
    a_clr: assert property (p_clr) else $error("ready not held low by clear");
    property p_rxoe; $stable(rx_data_output_disable_in) [*4]
        |-> rx_holding_data_oe_n_out == rx_data_output_disable_in; endproperty
    a_rxoe: assert property (p_rxoe) else $error("data enable wrong");
    property p_flgoe; $stable(flag_output_disable_in) [*4] |-> flags_oe_n_out == flag_output_disable_in
        && {rx_char_ready_oe_n_out, tx_holding_empty_oe_n_out} == {2{flag_output_disable_in}};
    endproperty
    a_flgoe: assert property (p_flgoe) else $error("flag enables wrong");
endmodule
bind pin_uart pin_uart_chk chk_u (.clk_sys_in, .reset_in, .master_reset_in, .tx_holding_load_n_in,
    .rx_ready_clear_n_in, .rx_data_output_disable_in, .flag_output_disable_in, .tx_serial_out_out,
    .tx_holding_empty_out, .tx_holding_empty_oe_n_out, .tx_shift_empty_out,
    .rx_holding_data_oe_n_out, .rx_char_ready_out, .rx_char_ready_oe_n_out, .overrun_fault_out,
    .flags_oe_n_out);

/* sim/serial_peer.sv */
// Remote serial peer: frame sender and frame sampler
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_NS = 640 // Sixteen ticks of the 16x clock
)(
    // Serial lines seen from the far end
    output logic     line_to_dut_out,
    input wire logic line_from_dut_in
);
    realtime t_start; // Time of the last start edge seen
    initial line_to_dut_out = 1'b1; // Idle mark
    // Send one frame; stop_ok low makes the first stop a space
    task automatic send(input logic [7:0] d, input int n, input bit pen,
                        input logic par, input logic stop_ok);
        line_to_dut_out = 1'b0; // Start bit
        #(BIT_NS);
        for (int i = 0; i < n; i++)
        begin
            line_to_dut_out = d[i]; // Least significant first
            #(BIT_NS);
        end
        if (pen)
        begin
            line_to_dut_out = par;
            #(BIT_NS);
        end
        line_to_dut_out = stop_ok;
        #(BIT_NS);
        line_to_dut_out = 1'b1; // Back to mark between frames
        #(2 * BIT_NS);
    endtask
    // Sample one frame at bit centres; returns at mid first stop
    task automatic recv(input int n, input bit pen, output logic [7:0] d,
                        output logic par, output logic stp);
        d = 8'h00;
        par = 1'b0;
        @(negedge line_from_dut_in);
        t_start = $realtime;
        #(BIT_NS / 2);
        for (int i = 0; i < n + int'(pen); i++)
        begin
            #(BIT_NS); // One bit cell per sixteen ticks
            if (i < n) d[i] = line_from_dut_in;
            else par = line_from_dut_in;
        end
        #(BIT_NS);
        stp = line_from_dut_in;
    endtask
endmodule

/* sim/tb_pin_programmed_async_uart.sv */
// Self-checking bench for the pin-programmed serial transceiver
`timescale 1ns/1ps
module tb_pin_programmed_async_uart;
    import uart_pkg::*;
    localparam int TICK_NS = 40; // 16x clock: eight system clocks a period
    localparam int BIT_NS = TICKS_PER_BIT * TICK_NS;
    // Control words {len, inhibit, even, stop}: every code at least once
    localparam logic [4:0] CW [4] = '{5'h01, 5'h0b, 5'h14, 5'h18};
    logic clk, rst, tck, rxl, txl, cwl, mr, tld_n, clr_n, rdis, fdis;
    logic the, the_oe, tse, rdat_oe, rdy, rdy_oe, pe, fe, oe, flg_oe;
    logic [4:0] cwp; // Control pins {sel1, sel0, inhibit, even, stop}
    logic [7:0] tdat, rdat;
    int err_total = 0, check_count = 0, cyc = 0;
    pin_uart dut_u (.clk_sys_in(clk), .reset_in(rst), .rx_bit_clock_16x_in(tck),
        .tx_bit_clock_16x_in(tck), .prescale_select_in(1'b0), .rx_serial_in(rxl),
        .tx_serial_out_out(txl), .ctrl_word_load_in(cwl), .char_len_sel_0_in(cwp[3]),
        .char_len_sel_1_in(cwp[4]), .parity_inhibit_in(cwp[2]), .even_parity_select_in(cwp[1]),
        .stop_len_select_in(cwp[0]), .tx_holding_data_in(tdat), .tx_holding_load_n_in(tld_n),
        .master_reset_in(mr), .tx_holding_empty_out(the), .tx_holding_empty_oe_n_out(the_oe),
        .tx_shift_empty_out(tse), .rx_ready_clear_n_in(clr_n), .rx_data_output_disable_in(rdis),
        .flag_output_disable_in(fdis), .rx_holding_data_out(rdat),
        .rx_holding_data_oe_n_out(rdat_oe), .rx_char_ready_out(rdy),
        .rx_char_ready_oe_n_out(rdy_oe), .rx_parity_fault_out(pe), .framing_fault_out(fe),
        .overrun_fault_out(oe), .flags_oe_n_out(flg_oe));
    serial_peer #(.BIT_NS(BIT_NS)) peer_u (.line_to_dut_out(rxl), .line_from_dut_in(txl));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // 16x clock shared by both directions, off the system edges
    initial
    begin
        tck = 1'b0;
        #1.3;
        forever #(TICK_NS / 2) tck = ~tck;
    end
    // Ceiling nearly three times the expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            complete_run();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [7:0] mask(input int n);
        return 8'hff >> (8 - n);
    endfunction
    function automatic logic par_of(input logic [7:0] d, input int n, input logic ev);
        return ^(d & mask(n)) ^ !ev;
    endfunction
    // Load control word, then scramble pins to show it is held
    task automatic cfg(input logic [4:0] w);
        cwp = w;
        cwl = 1'b1;
        step(5);
        cwl = 1'b0;
        step(4);
        cwp = ~w;
    endtask
    // Data held past the rising edge of the strobe
    task automatic load(input logic [7:0] d);
        tdat = d;
        tld_n = 1'b0;
        step(4);
        tld_n = 1'b1;
        step(4);
    endtask
    task automatic clear();
        clr_n = 1'b0;
        step(4);
        clr_n = 1'b1;
        step(4);
    endtask
    task automatic wait_tse();
        for (int i = 0; i < 3000 && tse !== 1'b1; i++) step(1);
    endtask
    // 5- and 6-bit formats sent with upper data bits set; frame length in ticks
    task automatic t_tx();
        logic [7:0] d, g;
        logic p, s;
        int n, e;
        for (int i = 0; i < 4; i++)
        begin
            cfg(CW[i]);
            n = 5 + int'(CW[i][4:3]);
            d = 8'hd6 + 8'(i * 37);
            e = 16 * (2 + n - int'(CW[i][2])) + (CW[i][0] ? (n == 5 ? 24 : 32) : 16);
            fork
                peer_u.recv(n, !CW[i][2], g, p, s);
                load(d);
            join
            wait_tse();
            chk("tx data", d & mask(n), g);
            chk("tx parity", {7'h0, CW[i][2] ? 1'b0 : par_of(d, n, CW[i][1])}, {7'h0, p});
            chk("tx stop", 8'h01, {7'h0, s});
            chk("tx ticks", 8'(e), 8'(int'(($realtime - peer_u.t_start) / TICK_NS)));
        end
        $display("test tx done");
    endtask
    // Second load while the first shifts: frames must abut
    task automatic t_b2b();
        logic [7:0] g;
        logic p, s;
        realtime t0;
        fork
            begin
                peer_u.recv(8, 1'b1, g, p, s);
                t0 = peer_u.t_start;
                chk("first", 8'h3c, g);
                peer_u.recv(8, 1'b1, g, p, s);
                chk("second", 8'hc3, g);
                chk("gap", 8'hb0, 8'(int'((peer_u.t_start - t0) / TICK_NS)));
            end
            begin
                load(8'h3c);
                for (int i = 0; i < 100 && the !== 1'b1; i++) step(1);
                chk("holding empty", 8'h01, {7'h0, the});
                load(8'hc3);
            end
        join
        wait_tse();
        $display("test b2b done");
    endtask
    task automatic t_rx();
        logic [7:0] d;
        int n;
        for (int i = 0; i < 4; i++)
        begin
            cfg(CW[i]);
            n = 5 + int'(CW[i][4:3]);
            d = 8'ha7 - 8'(i * 29);
            peer_u.send(d, n, !CW[i][2], par_of(d, n, CW[i][1]), 1'b1);
            step(2);
            chk("rx data", d & mask(n), rdat);
            chk("rx ready", 8'h01, {7'h0, rdy});
            chk("rx flags", 8'h00, {5'h0, pe, fe, oe});
            clear();
            chk("rx cleared", 8'h00, {7'h0, rdy});
        end
        $display("test rx done");
    endtask
    // Faults in sequence on 8-bit odd-parity frames, then master reset
    task automatic t_err();
        logic [7:0] d = 8'h5a;
        logic gp = ~^8'h5a;
        peer_u.send(d, 8, 1'b1, ~gp, 1'b1);
        step(2);
        chk("parity fault", 8'h04, {5'h0, pe, fe, oe});
        clear();
        peer_u.send(d, 8, 1'b1, gp, 1'b0);
        step(2);
        chk("framing fault", 8'h02, {5'h0, pe, fe, oe});
        peer_u.send(d, 8, 1'b1, gp, 1'b1);
        step(2);
        chk("overrun", 8'h01, {5'h0, pe, fe, oe});
        clear();
        peer_u.send(~d, 8, 1'b1, gp, 1'b1);
        step(2);
        chk("overrun gone", 8'h00, {5'h0, pe, fe, oe});
        peer_u.send(d, 8, 1'b1, ~gp, 1'b1);
        step(2);
        chk("two faults", 8'h05, {5'h0, pe, fe, oe});
        mr = 1'b1;
        step(5);
        chk("reset outputs", 8'h03, {1'h0, rdy, oe, pe, fe, tse, txl, the});
        chk("data kept", d, rdat);
        mr = 1'b0;
        step(18 * 8); // Eighteen ticks of the 16x clock
        chk("shift empty", 8'h01, {7'h0, tse});
        $display("test err done");
    endtask
    task automatic t_oe();
        {rdis, fdis} = 2'h3;
        step(5);
        chk("float", 8'h0f, {4'h0, rdat_oe, flg_oe, rdy_oe, the_oe});
        {rdis, fdis} = 2'h0;
        step(5);
        chk("drive", 8'h00, {4'h0, rdat_oe, flg_oe, rdy_oe, the_oe});
        $display("test oe done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        {rst, mr, cwl, rdis, fdis, tld_n, clr_n} = 7'h43; // Reset on, strobes idle
        cwp = 5'h00;
        tdat = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        mr = 1'b1;
        step(5);
        mr = 1'b0;
        wait_tse();
        t_tx();
        t_b2b();
        t_rx();
        t_err();
        t_oe();
        complete_run();
    end
endmodule
